// ==== logic/buck3_defs.svh ====
// Offsets, field positions, reset values and decode figures of the third buck register bank.
`ifndef BUCK3_DEFS_SVH
`define BUCK3_DEFS_SVH

// ======================================================================
// Register offsets
`define OFS_STANDBY_CODE  8'h30
`define OFS_RESERVED      8'h31
`define OFS_ENABLE_STATUS 8'h32
`define OFS_NORMAL_CODE   8'h33

// ======================================================================
// Field positions
`define BIT_ENABLE        0
`define BIT_POWER_GOOD    1
`define BIT_FAULT_MASK_N  2
`define BIT_RANGE_SELECT  6
`define CODE_MSB          5

// ======================================================================
// Reset values and read value of read-only bits
`define RST_STANDBY_CODE  6'h00
`define RST_NORMAL_CODE   6'h00
`define RST_RANGE_SELECT  1'h0
`define RST_ENABLE        1'h0
`define RST_FAULT_MASK_N  1'h0
`define RO_FILL           8'h00
`define UNMAPPED_READ     8'h00

// ======================================================================
// Voltage decode figures in millivolts
`define MV_BAND0_BASE     13'h0271
`define MV_BAND1_BASE     13'h0401
`define MV_BAND2_BASE     13'h0591
`define MV_BAND3_BASE     13'h0721
`define MV_STEP           13'h0019
`define MV_BAND0_FLOOR    13'h0320
`define MV_BAND2_STEP2    13'h05c8
`define CODE_ADJUSTABLE   6'h00

`endif

// ==== logic/buck3_pkg.sv ====
// Types shared by the third buck register bank and its helpers.
package buck3_pkg;

  // ======================================================================
  // Register selection decoded from the offset
  typedef enum logic [2:0] {
    SEL_NONE    = 3'b000,
    SEL_STANDBY = 3'b001,
    SEL_RESERVD = 3'b010,
    SEL_CONTROL = 3'b011,
    SEL_NORMAL  = 3'b100
  } reg_sel_e;

  typedef logic [12:0] mv_t;
  typedef logic [5:0]  vcode_t;

endpackage

// ==== logic/pgood_sync.sv ====
// Two-stage synchroniser for the converter's power-good level.
module pgood_sync (
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic level_in,
  output logic      level_out
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // ======================================================================
  // Only the second stage is ever read outside this module.
  always_comb begin
    meta_d = level_in;
    sync_d = meta_q;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign level_out = sync_q;

endmodule

// ==== logic/vcode_decoder.sv ====
// Registered decoder from a six-bit voltage code and range bit to millivolts.
`include "buck3_defs.svh"

module vcode_decoder (
  input  wire logic            CLK,
  input  wire logic            NRST,
  input  wire buck3_pkg::vcode_t code,
  input  wire logic            range_high,
  output buck3_pkg::mv_t       millivolts,
  output logic                 adjustable
);

  buck3_pkg::mv_t mv_q;
  buck3_pkg::mv_t mv_d;
  logic           adj_q;
  logic           adj_d;

  // Stepped value of a code before the low range floor and 0x22 overrides; the high range is twice this figure.
  function automatic buck3_pkg::mv_t low_mv(input buck3_pkg::vcode_t c);
    buck3_pkg::mv_t base;
    buck3_pkg::mv_t v;
    case (c[5:4])
      2'b00:   base = `MV_BAND0_BASE;
      2'b01:   base = `MV_BAND1_BASE;
      2'b10:   base = `MV_BAND2_BASE;
      default: base = `MV_BAND3_BASE;
    endcase
    v = 13'(base + 13'(c[3:0]) * `MV_STEP);
    return v;
  endfunction

  // ======================================================================
  // R8 band and step decode.
  always_comb begin
    mv_d  = low_mv(code);
    adj_d = (code == `CODE_ADJUSTABLE);
    if (range_high) begin
      mv_d = 13'(mv_d << 1);
    end else if (code[5:4] == 2'b00 && !code[3]) begin
      mv_d = `MV_BAND0_FLOOR;
    end else if (code == 6'h22) begin
      mv_d = `MV_BAND2_STEP2;
    end
    // R9 code zero selects the external divider.
    if (adj_d) begin
      mv_d = 13'h0000;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mv_q  <= 13'h0000;
      adj_q <= 1'b0;
    end else begin
      mv_q  <= mv_d;
      adj_q <= adj_d;
    end
  end

  assign millivolts = mv_q;
  assign adjustable = adj_q;

  // ======================================================================
  // Assertions on the decode.
  adjust_code_a : assert property (@(posedge CLK) disable iff (!NRST) // R9
    code == `CODE_ADJUSTABLE |=> adjustable && millivolts == 13'h0000)
    else $error("Code zero did not select the adjustable option.");

  top_code_a : assert property (@(posedge CLK) disable iff (!NRST) // R8
    code == 6'h3f && range_high |=> millivolts == 13'h1130)
    else $error("Top high range code did not decode to 4400 mV.");

  floor_code_a : assert property (@(posedge CLK) disable iff (!NRST) // R8
    code[5:3] == 3'b000 && code != `CODE_ADJUSTABLE && !range_high
    |=> millivolts == `MV_BAND0_FLOOR)
    else $error("Low band code did not clamp to 800 mV.");

  cover_adjust_c : cover property (@(posedge CLK) disable iff (!NRST)
    code == `CODE_ADJUSTABLE ##1 adjustable);

endmodule

// ==== logic/buck3_regs.sv ====
// Control and status register bank of the third step-down converter.
// How it works
// R1 - 0x30 holds standby code, bits 7:6 read-only.
// R2 - 0x31 and read-only bits ignore writes.
// R3 - 0x32 bit 0 enables the converter.
// R4 - 0x32 bit 1 reads power-good state.
// R5 - 0x32 bit 2 fault mask, low masks.
// R6 - 0x33 holds normal code, bit 7 read-only.
// R7 - 0x33 bit 6 selects low or high range.
// R8 - Code bands step 25 mV, high range doubles.
// R9 - Code zero selects external feedback divider.
// R10 - Second converter codes use the same decode.
// R11 - Host writes exact bits only with defaults.
// R12 - Host reads and writes these registers.
// R13 - Select pin low uses normal, high standby.
// R14 - Power-good clears when output falls low.
// R15 - Host sets range before writing code; the bench writes range and code together in one byte to 0x33.
// R16 - Power-good is synchronised before being read.
`include "buck3_defs.svh"

module buck3_regs (
  input  wire logic              CLK,
  input  wire logic              NRST,
  // Register port from the serial interface engine.
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic              REG_WR,
  input  wire logic [7:0]        REG_WDATA,
  input  wire logic              REG_RD,
  output logic [7:0]             REG_RDATA,
  output logic                   REG_RVALID,
  // Converter side.
  input  wire logic              POWER_GOOD_IN,
  input  wire logic              VOLTAGE_SELECT_PIN,
  output logic                   BUCK_ENABLE,
  output logic                   FAULT_MASK_N,
  output logic                   RANGE_SELECT,
  output buck3_pkg::vcode_t      VOLTAGE_CODE,
  output buck3_pkg::mv_t         TARGET_MV,
  output logic                   ADJUSTABLE,
  // Second converter decode.
  input  wire buck3_pkg::vcode_t SECOND_CODE,
  input  wire logic              SECOND_RANGE,
  output buck3_pkg::mv_t         SECOND_MV,
  output logic                   SECOND_ADJUSTABLE
);

  buck3_pkg::vcode_t  standby_code_q;
  buck3_pkg::vcode_t  standby_code_d;
  buck3_pkg::vcode_t  normal_code_q;
  buck3_pkg::vcode_t  normal_code_d;
  logic               range_q;
  logic               range_d;
  logic               enable_q;
  logic               enable_d;
  logic               mask_n_q;
  logic               mask_n_d;
  buck3_pkg::vcode_t  vcode_q;
  buck3_pkg::vcode_t  vcode_d;
  logic               range_out_q;
  logic               range_out_d;
  logic [7:0]         rdata_q;
  logic [7:0]         rdata_d;
  logic               rvalid_q;
  logic               rvalid_d;
  logic               pgood;
  buck3_pkg::reg_sel_e sel;

  // Read-only bits all read back as this fill value.
  localparam logic [7:0] ro_fill = `RO_FILL;

  // Maps an offset onto the register it selects.
  function automatic buck3_pkg::reg_sel_e decode_sel(input logic [7:0] addr);
    buck3_pkg::reg_sel_e s;
    case (addr)
      `OFS_STANDBY_CODE:  s = buck3_pkg::SEL_STANDBY;
      `OFS_RESERVED:      s = buck3_pkg::SEL_RESERVD;
      `OFS_ENABLE_STATUS: s = buck3_pkg::SEL_CONTROL;
      `OFS_NORMAL_CODE:   s = buck3_pkg::SEL_NORMAL;
      default:            s = buck3_pkg::SEL_NONE;
    endcase
    return s;
  endfunction

  // ======================================================================
  // Power-good input synchronisation
  // R16 synchronise power-good.
  // R14 live status clears.
  pgood_sync u_pgood_sync (
    .CLK       (CLK),
    .NRST      (NRST),
    .level_in  (POWER_GOOD_IN),
    .level_out (pgood)
  );

  assign sel = decode_sel(REG_ADDR);

  // ======================================================================
  // Register write path
  // Next values of the writable fields; other offsets leave them alone.
  // R12 host register writes.
  always_comb begin
    standby_code_d = standby_code_q;
    normal_code_d  = normal_code_q;
    range_d        = range_q;
    enable_d       = enable_q;
    mask_n_d       = mask_n_q;
    if (REG_WR) begin
      case (sel)
        // R1 standby code write.
        buck3_pkg::SEL_STANDBY: begin
          standby_code_d = REG_WDATA[`CODE_MSB:0];
        end
        // R3 enable and R5 mask write.
        buck3_pkg::SEL_CONTROL: begin
          enable_d = REG_WDATA[`BIT_ENABLE];
          mask_n_d = REG_WDATA[`BIT_FAULT_MASK_N];
        end
        // R6 normal code and R7 range write.
        buck3_pkg::SEL_NORMAL: begin
          normal_code_d = REG_WDATA[`CODE_MSB:0];
          range_d       = REG_WDATA[`BIT_RANGE_SELECT];
        end
        // R2 reserved writes ignored.
        default: begin
          standby_code_d = standby_code_q;
        end
      endcase
    end
  end

  // Writable fields are cleared by reset.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      standby_code_q <= `RST_STANDBY_CODE;
      normal_code_q  <= `RST_NORMAL_CODE;
      range_q        <= `RST_RANGE_SELECT;
      enable_q       <= `RST_ENABLE;
      mask_n_q       <= `RST_FAULT_MASK_N;
    end else begin
      standby_code_q <= standby_code_d;
      normal_code_q  <= normal_code_d;
      range_q        <= range_d;
      enable_q       <= enable_d;
      mask_n_q       <= mask_n_d;
    end
  end

  // ======================================================================
  // Register read path
  // Read data is captured one cycle after the strobe; read-only bits fill with a constant.
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = REG_RD;
    if (REG_RD) begin
      case (sel)
        buck3_pkg::SEL_STANDBY: begin
          rdata_d = {ro_fill[7:6], standby_code_q};
        end
        buck3_pkg::SEL_RESERVD: begin
          rdata_d = `RO_FILL;
        end
        // R4 power-good read.
        buck3_pkg::SEL_CONTROL: begin
          rdata_d = {ro_fill[7:3], mask_n_q, pgood, enable_q};
        end
        buck3_pkg::SEL_NORMAL: begin
          rdata_d = {ro_fill[7], range_q, normal_code_q};
        end
        default: begin
          rdata_d = `UNMAPPED_READ;
        end
      endcase
    end
  end

  // Read answer and its one-cycle valid pulse.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ======================================================================
  // Voltage selection toward the converter
  // R13 pin picks the active code.
  always_comb begin
    vcode_d     = VOLTAGE_SELECT_PIN ? standby_code_q : normal_code_q;
    range_out_d = range_q;
  end

  // Active code and range toward the converter.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      vcode_q     <= `RST_NORMAL_CODE;
      range_out_q <= `RST_RANGE_SELECT;
    end else begin
      vcode_q     <= vcode_d;
      range_out_q <= range_out_d;
    end
  end

  // ======================================================================
  // Decoders for this converter and the second one
  // R8 decode the active code.
  vcode_decoder u_own_decoder (
    .CLK        (CLK),
    .NRST       (NRST),
    .code       (vcode_q),
    .range_high (range_out_q),
    .millivolts (TARGET_MV),
    .adjustable (ADJUSTABLE)
  );

  // R10 shared decode table.
  vcode_decoder u_second_decoder (
    .CLK        (CLK),
    .NRST       (NRST),
    .code       (SECOND_CODE),
    .range_high (SECOND_RANGE),
    .millivolts (SECOND_MV),
    .adjustable (SECOND_ADJUSTABLE)
  );

  // Outputs come straight from flip-flops.
  assign REG_RDATA    = rdata_q;
  assign REG_RVALID   = rvalid_q;
  assign BUCK_ENABLE  = enable_q;
  assign FAULT_MASK_N = mask_n_q;
  assign RANGE_SELECT = range_out_q;
  assign VOLTAGE_CODE = vcode_q;

  // ======================================================================
  // Assertions
  standby_write_a : assert property (@(posedge CLK) disable iff (!NRST) // R1
    REG_WR && REG_ADDR == `OFS_STANDBY_CODE
    |=> standby_code_q == $past(REG_WDATA[5:0]))
    else $error("Standby code write not stored.");

  reserved_write_a : assert property (@(posedge CLK) disable iff (!NRST) // R2
    REG_WR && REG_ADDR == `OFS_RESERVED
    |=> $stable(standby_code_q) && $stable(normal_code_q) && $stable(enable_q)
        && $stable(mask_n_q) && $stable(range_q))
    else $error("Write to reserved offset changed state.");

  enable_write_a : assert property (@(posedge CLK) disable iff (!NRST) // R3
    REG_WR && REG_ADDR == `OFS_ENABLE_STATUS |=> BUCK_ENABLE == $past(REG_WDATA[0]))
    else $error("Enable write did not reach the converter.");

  pgood_read_a : assert property (@(posedge CLK) disable iff (!NRST) // R4
    REG_RD && REG_ADDR == `OFS_ENABLE_STATUS
    |=> REG_RVALID && REG_RDATA[1] == $past(pgood) && REG_RDATA[7:3] == 5'h00)
    else $error("Status read shows wrong power-good or read-only bits.");

  mask_write_a : assert property (@(posedge CLK) disable iff (!NRST) // R5
    REG_WR && REG_ADDR == `OFS_ENABLE_STATUS |=> FAULT_MASK_N == $past(REG_WDATA[2]))
    else $error("Fault mask write not applied.");

  normal_write_a : assert property (@(posedge CLK) disable iff (!NRST) // R6
    REG_WR && REG_ADDR == `OFS_NORMAL_CODE |=> normal_code_q == $past(REG_WDATA[5:0])
    ##1 RANGE_SELECT == $past(REG_WDATA[6], 2))
    else $error("Normal code or range write not applied.");

  code_select_a : assert property (@(posedge CLK) disable iff (!NRST) // R13
    VOLTAGE_SELECT_PIN |=> VOLTAGE_CODE == $past(standby_code_q))
    else $error("Active code does not follow the standby setting.");

  normal_select_a : assert property (@(posedge CLK) disable iff (!NRST) // R13
    !VOLTAGE_SELECT_PIN |=> VOLTAGE_CODE == $past(normal_code_q))
    else $error("Active code does not follow the normal setting.");

  read_pulse_a : assert property (@(posedge CLK) disable iff (!NRST) // R12
    REG_RVALID == $past(REG_RD))
    else $error("Read answer did not stand exactly one cycle after the strobe.");

  standby_read_a : assert property (@(posedge CLK) disable iff (!NRST) // R1
    REG_RD && REG_ADDR == `OFS_STANDBY_CODE
    |=> REG_RDATA == {ro_fill[7:6], $past(standby_code_q)})
    else $error("Standby read shows wrong code or read-only bits.");

  reserved_read_a : assert property (@(posedge CLK) disable iff (!NRST) // R2
    REG_RD && REG_ADDR == `OFS_RESERVED |=> REG_RDATA == ro_fill)
    else $error("Reserved read did not return the fill value.");

  range_read_a : assert property (@(posedge CLK) disable iff (!NRST) // R7
    REG_RD && REG_ADDR == `OFS_NORMAL_CODE
    |=> REG_RDATA == {ro_fill[7], $past(range_q), $past(normal_code_q)})
    else $error("Normal read shows wrong range, code or read-only bit.");

  enable_hold_a : assert property (@(posedge CLK) disable iff (!NRST) // R3
    REG_WR && REG_ADDR != `OFS_ENABLE_STATUS
    |=> $stable(BUCK_ENABLE) && $stable(FAULT_MASK_N))
    else $error("Write to another offset changed the enable or mask.");

  pgood_clear_a : assert property (@(posedge CLK) disable iff (!NRST) // R14
    (!POWER_GOOD_IN)[*3] |-> !pgood)
    else $error("Power-good flag did not clear.");

  cover_enable_c : cover property (@(posedge CLK) disable iff (!NRST)
    REG_WR && REG_ADDR == `OFS_ENABLE_STATUS ##1 BUCK_ENABLE);

  cover_select_c : cover property (@(posedge CLK) disable iff (!NRST)
    !VOLTAGE_SELECT_PIN ##1 VOLTAGE_SELECT_PIN);

  cover_pgood_c : cover property (@(posedge CLK) disable iff (!NRST)
    pgood ##1 !pgood);

endmodule

// ==== tb/host_model.sv ====
// Host-side model that reaches the register bank one byte at a time.
module host_model (
  input  wire logic       clk,
  output logic [7:0]      addr,
  output logic            wr,
  output logic [7:0]      wdata,
  output logic            rd,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // ======================================================================
  // Idle port
  // Strobes start low so no request reaches the bank during reset.
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
  end

  // ======================================================================
  // Register cycles
  // whole byte writes
  // One strobe cycle; the caller writes range and code together in one byte.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask

  // single byte reads
  // The answer is taken one cycle after the strobe, then the address is scrambled.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    ok = rvalid;
    d = rdata;
    rd = 1'b0;
    addr = ~a;
  endtask
endmodule

// ==== tb/buck3_regs_tb.sv ====
// Self-checking bench for the third buck register bank.
module buck3_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ======================================================================
  // Signals and decode table
  typedef struct {
    logic        rng;
    logic [5:0]  code;
    logic [12:0] mv;
  } row_s;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr, wdata, rdata, rd_val;
  logic        wr, rd, rvalid, v, en, mask_n, rng_o, adj, sadj;
  logic        pg = 1'b0;
  logic        voltage_select_pin = 1'b0;
  logic        srng = 1'b0;
  logic [5:0]  scode = 6'h00;
  logic [5:0]  vcode;
  logic [12:0] mv, smv;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  row_s        rows [12] = '{'{1'b0, 6'h01, 13'h0320}, '{1'b0, 6'h07, 13'h0320},
    '{1'b0, 6'h08, 13'h0339}, '{1'b0, 6'h0f, 13'h03e8}, '{1'b0, 6'h10, 13'h0401},
    '{1'b0, 6'h22, 13'h05c8}, '{1'b0, 6'h3f, 13'h0898}, '{1'b1, 6'h01, 13'h0514},
    '{1'b1, 6'h07, 13'h0640}, '{1'b1, 6'h20, 13'h0b22}, '{1'b1, 6'h3f, 13'h1130},
    '{1'b0, 6'h00, 13'h0000}};

  // ======================================================================
  // Design and host
  buck3_regs buck3_regs_i (
    .CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
    .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .POWER_GOOD_IN(pg),
    .VOLTAGE_SELECT_PIN(voltage_select_pin), .BUCK_ENABLE(en), .FAULT_MASK_N(mask_n),
    .RANGE_SELECT(rng_o), .VOLTAGE_CODE(vcode), .TARGET_MV(mv), .ADJUSTABLE(adj),
    .SECOND_CODE(scode), .SECOND_RANGE(srng), .SECOND_MV(smv), .SECOND_ADJUSTABLE(sadj));
  host_model host_model_i (
    .clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd), .rdata(rdata), .rvalid(rvalid));

  // Clock of 10 ns period.
  always #5 clk = ~clk;

  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ======================================================================
  // Helpers
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_model_i.read_reg(a, rd_val, v);
    check("read valid", 16'h0001, {15'h0000, v});
    check("read data", {8'h00, exp}, {8'h00, rd_val});
    @(negedge clk);
    check("read valid low", 16'h0000, {15'h0000, rvalid});
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ======================================================================
  // Main sequence
  initial begin
    wait_n(16);
    nrst = 1'b1;
    wait_n(3);
    check("adjustable", 16'h0001, {15'h0000, adj});
    for (int i = 0; i < 4; i++) rd_chk(8'h30 + 8'(i), 8'h00);
    // Each row drives both decoders; bit 7 is written high and must read back low.
    foreach (rows[i]) begin
      scode = rows[i].code;
      srng = rows[i].rng;
      host_model_i.write_reg(8'h33, {1'b1, rows[i].rng, rows[i].code});
      wait_n(3);
      check("second mv", {3'h0, rows[i].mv}, {3'h0, smv});
      check("second adj", {15'h0000, rows[i].code == 6'h00}, {15'h0000, sadj});
      check("target mv", {3'h0, rows[i].mv}, {3'h0, mv});
      check("adjustable", {15'h0000, rows[i].code == 6'h00}, {15'h0000, adj});
      check("range out", {15'h0000, rows[i].rng}, {15'h0000, rng_o});
      rd_chk(8'h33, {1'b0, rows[i].rng, rows[i].code});
    end
    // Standby code is used only while the select pin is high.
    host_model_i.write_reg(8'h30, 8'hff);
    rd_chk(8'h30, 8'h3f);
    voltage_select_pin = 1'b1;
    wait_n(3);
    check("code sel", 16'h003f, {10'h000, vcode});
    check("standby mv", 16'h0898, {3'h0, mv});
    voltage_select_pin = 1'b0;
    wait_n(3);
    check("code sel", 16'h0000, {10'h000, vcode});
    // The reserved place ignores writes; reserved and unmapped places read zero.
    host_model_i.write_reg(8'h31, 8'hff);
    rd_chk(8'h31, 8'h00);
    rd_chk(8'h40, 8'h00);
    rd_chk(8'h30, 8'h3f);
    rd_chk(8'h33, 8'h00);
    host_model_i.write_reg(8'h32, 8'hfd);
    check("enable", 16'h0001, {15'h0000, en});
    check("mask_n", 16'h0001, {15'h0000, mask_n});
    rd_chk(8'h32, 8'h05);
    host_model_i.write_reg(8'h32, 8'h02);
    rd_chk(8'h32, 8'h00);
    check("enable", 16'h0000, {15'h0000, en});
    check("mask_n", 16'h0000, {15'h0000, mask_n});
    // Power-good follows the converter through the synchroniser.
    pg = 1'b1;
    wait_n(3);
    rd_chk(8'h32, 8'h02);
    pg = 1'b0;
    wait_n(3);
    rd_chk(8'h32, 8'h00);
    // A reset in mid-run clears the enable and the standby code.
    host_model_i.write_reg(8'h32, 8'h05);
    nrst = 1'b0;
    wait_n(2);
    check("enable", 16'h0000, {15'h0000, en});
    nrst = 1'b1;
    wait_n(2);
    rd_chk(8'h32, 8'h00);
    rd_chk(8'h30, 8'h00);
    wrap_up();
  end
endmodule
